/* File: src/frc_pkg.sv */
// Package for the fault response configuration block.
package frc_pkg;
   localparam logic [7:0] CMD_OC = 8'h47;
   localparam logic [7:0] CMD_OT = 8'h50;
   localparam logic [7:0] CMD_VIN_HIGH = 8'h56;
   localparam logic [7:0] CMD_VIN_LOW = 8'h5A;
   localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
   localparam int NUM_FAULTS = 4;
   localparam int IDX_OC = 0;
   localparam int IDX_OT = 1;
   localparam int IDX_VIN_HIGH = 2;
   localparam int IDX_VIN_LOW = 3;
   localparam int ACTION_MSB = 7;
   localparam int ACTION_LSB = 6;
   localparam int RESTART_MSB = 5;
   localparam int RESTART_LSB = 3;
   localparam int WP_LOCK_FULL_BIT = 7;
   localparam logic [1:0] ACTION_IGNORE = 2'h0;
   localparam logic [1:0] ACTION_SHUT_OC = 2'h3;
   localparam logic [1:0] ACTION_SHUT_OTHER = 2'h2;
   localparam logic [2:0] RESTART_LATCH = 3'h0;
   localparam logic [2:0] RESTART_MAX_FINITE = 3'h6;
   localparam logic [2:0] RESTART_UNLIMITED = 3'h7;
   localparam logic [7:0] RESET_OC = 8'hC0;
   localparam logic [7:0] RESET_OT = 8'h80;
   localparam logic [7:0] RESET_VIN_HIGH = 8'hB8;
   localparam logic [7:0] RESET_VIN_LOW = 8'hB8;
   localparam logic [7:0] RESET_WRITE_PROTECT = 8'h00;
   localparam logic [7:0] RSVD_MASK = 8'hF8;
   localparam logic [7:0] WP_MASK = 8'hC0;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] cmd;
      logic [7:0] data;
   } frc_req_s;

   typedef struct packed {
      logic [1:0] action;
      logic [2:0] restart_count;
   } frc_cfg_s;
endpackage : frc_pkg

/* File: src/frc_retry.sv */
// Retry tracker for one fault type.
`timescale 1ns/1ps
module frc_retry (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Configuration and fault events.
   input frc_pkg::frc_cfg_s cfg,
   input wire logic shut_code,
   input wire logic fault,
   input wire logic gate_on_cmd,
   // Results.
   output logic shut_req,
   output logic latched_off,
   output logic [2:0] attempts
);
   logic [2:0] cnt_r;
   logic latch_r;
   logic shuts;
   logic [1:0] shut_val;
   logic [2:0] cnt_eff;

   // A fault shuts the gate only when its action code is the shutdown code.
   assign shut_val = shut_code ? frc_pkg::ACTION_SHUT_OC
                               : frc_pkg::ACTION_SHUT_OTHER;
   assign shuts = fault && (cfg.action == shut_val);
   // A gate-on command in the same cycle counts from a cleared counter.
   assign cnt_eff = gate_on_cmd ? 3'h0 : cnt_r;
   assign shut_req = shuts;
   assign latched_off = latch_r;
   assign attempts = cnt_r;

   ////////////////////////////////////////////////////////////////////////
   // Restart counting.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 3'h0;
      end else if (gate_on_cmd) begin
         cnt_r <= {2'h0, shuts};
      end else if (shuts && !latch_r && cnt_r != 3'h7) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         latch_r <= 1'b0;
      end else if (shuts &&
                   cfg.restart_count == frc_pkg::RESTART_LATCH) begin
         latch_r <= 1'b1;
      end else if (shuts &&
                   cfg.restart_count != frc_pkg::RESTART_UNLIMITED &&
                   cnt_eff >= cfg.restart_count) begin
         latch_r <= 1'b1;
      end else if (gate_on_cmd) begin
         latch_r <= 1'b0;
      end
   end

   property p_latch_zero;
      @(posedge clk) disable iff (rst)
      (shuts && cfg.restart_count == frc_pkg::RESTART_LATCH) |=> latch_r;
   endproperty
   a_latch_zero: assert property (p_latch_zero)
      else $error("Latch-off code did not latch.");

   property p_unlimited;
      @(posedge clk) disable iff (rst)
      (!latch_r && cfg.restart_count == frc_pkg::RESTART_UNLIMITED &&
       !gate_on_cmd) |=> !latch_r;
   endproperty
   a_unlimited: assert property (p_unlimited)
      else $error("Unlimited retries latched off.");

   property p_clear_on;
      @(posedge clk) disable iff (rst)
      (gate_on_cmd && !shuts) |=> (cnt_r == 3'h0 && !latch_r);
   endproperty
   a_clear_on: assert property (p_clear_on)
      else $error("Gate-on command did not clear retry state.");

   property p_ignore;
      @(posedge clk) disable iff (rst)
      (cfg.action == frc_pkg::ACTION_IGNORE) |-> !shut_req;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("Ignored fault requested shutdown.");
endmodule : frc_retry

/* File: src/frc_top.sv */
// Fault response configuration registers and per-fault shutdown logic.
// Notes on behaviour
// - Action field bits 7:6; 00 ignores the fault, gate stays on.
// - Retry 000 latches off, 001..110 that many retries, 111 unlimited.
// - Overcurrent action 11 shuts down; resets to 11 with latch-off.
// - Overtemperature action 10 shuts down; resets to 10, latch-off.
// - Input high action 10 shuts down; resets to 10, unlimited.
// - Input low action 10 shuts down; resets to 10, unlimited.
// - Retry bits 5:3; bits 2:0 ignore writes and read zero.
// - Full write lock blocks these writes; protect register stays writable.
`timescale 1ns/1ps
module frc_top (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Command port.
   input frc_pkg::frc_req_s req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic wr_refused,
   // Fault events and gate control.
   input wire logic [3:0] fault_in,
   input wire logic gate_on_cmd,
   output logic gate_off,
   output logic [3:0] latched_off,
   output logic write_lock_full
);
   logic [7:0] resp_r [frc_pkg::NUM_FAULTS];
   logic [7:0] wp_r;
   logic [7:0] rd_nxt;
   logic [3:0] sel;
   logic [3:0] shut_req;
   logic [3:0] lat;
   logic [7:0] rst_val [frc_pkg::NUM_FAULTS];
   logic [7:0] cmd_code [frc_pkg::NUM_FAULTS];
   logic [3:0] shut_is_oc;
   logic locked;

   assign rst_val[frc_pkg::IDX_OC] = frc_pkg::RESET_OC;
   assign rst_val[frc_pkg::IDX_OT] = frc_pkg::RESET_OT;
   assign rst_val[frc_pkg::IDX_VIN_HIGH] = frc_pkg::RESET_VIN_HIGH;
   assign rst_val[frc_pkg::IDX_VIN_LOW] = frc_pkg::RESET_VIN_LOW;
   assign cmd_code[frc_pkg::IDX_OC] = frc_pkg::CMD_OC;
   assign cmd_code[frc_pkg::IDX_OT] = frc_pkg::CMD_OT;
   assign cmd_code[frc_pkg::IDX_VIN_HIGH] = frc_pkg::CMD_VIN_HIGH;
   assign cmd_code[frc_pkg::IDX_VIN_LOW] = frc_pkg::CMD_VIN_LOW;
   assign shut_is_oc = 4'h1;
   assign locked = wp_r[frc_pkg::WP_LOCK_FULL_BIT];
   assign write_lock_full = locked;

   ////////////////////////////////////////////////////////////////////////
   // Write protect register stays writable under the lock.
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= frc_pkg::RESET_WRITE_PROTECT;
      end else if (req.wr && req.cmd == frc_pkg::CMD_WRITE_PROTECT) begin
         wp_r <= req.data & frc_pkg::WP_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault response registers and retry trackers.
   genvar g;
   generate
      for (g = 0; g < frc_pkg::NUM_FAULTS; g++) begin : g_fault
         frc_pkg::frc_cfg_s cfg;
         assign sel[g] = (req.cmd == cmd_code[g]);
         assign cfg.action =
            resp_r[g][frc_pkg::ACTION_MSB:frc_pkg::ACTION_LSB];
         assign cfg.restart_count =
            resp_r[g][frc_pkg::RESTART_MSB:frc_pkg::RESTART_LSB];

         always_ff @(posedge clk) begin
            if (rst) begin
               resp_r[g] <= rst_val[g];
            end else if (req.wr && sel[g] && !locked) begin
               resp_r[g] <= req.data & frc_pkg::RSVD_MASK;
            end
         end

         frc_retry u_retry (
            .clk(clk),
            .rst(rst),
            .cfg(cfg),
            .shut_code(shut_is_oc[g]),
            .fault(fault_in[g]),
            .gate_on_cmd(gate_on_cmd),
            .shut_req(shut_req[g]),
            .latched_off(lat[g]),
            .attempts()
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Gate shutdown and read port.
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_off <= 1'b0;
      end else if (|shut_req) begin
         gate_off <= 1'b1;
      end else if (gate_on_cmd) begin
         gate_off <= 1'b0;
      end
   end

   assign latched_off = lat;

   always_comb begin
      rd_nxt = 8'h00;
      for (int i = 0; i < frc_pkg::NUM_FAULTS; i++) begin
         if (sel[i]) begin
            rd_nxt = resp_r[i] & frc_pkg::RSVD_MASK;
         end
      end
      if (req.cmd == frc_pkg::CMD_WRITE_PROTECT) begin
         rd_nxt = wp_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         wr_refused <= 1'b0;
      end else begin
         rd_valid <= req.rd;
         if (req.rd) begin
            rd_data <= rd_nxt;
         end
         wr_refused <= req.wr && locked && (|sel);
      end
   end

   property p_lock;
      @(posedge clk) disable iff (rst)
      (req.wr && locked && sel[frc_pkg::IDX_OC])
         |=> $stable(resp_r[frc_pkg::IDX_OC]) && wr_refused;
   endproperty
   a_lock: assert property (p_lock)
      else $error("Locked write changed overcurrent register.");

   property p_rsvd;
      @(posedge clk) disable iff (rst)
      req.rd |=> rd_valid && (rd_data[2:0] == 3'h0);
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("Reserved bits read nonzero.");

   property p_oc_reset;
      @(posedge clk) $fell(rst) |-> resp_r[frc_pkg::IDX_OC] == 8'hC0;
   endproperty
   a_oc_reset: assert property (p_oc_reset)
      else $error("Overcurrent reset value wrong.");

   property p_ot_reset;
      @(posedge clk) $fell(rst) |-> resp_r[frc_pkg::IDX_OT] == 8'h80;
   endproperty
   a_ot_reset: assert property (p_ot_reset)
      else $error("Overtemperature reset value wrong.");

   property p_vh_reset;
      @(posedge clk) $fell(rst) |-> resp_r[frc_pkg::IDX_VIN_HIGH] == 8'hB8;
   endproperty
   a_vh_reset: assert property (p_vh_reset)
      else $error("Input high reset value wrong.");

   property p_vl_reset;
      @(posedge clk) $fell(rst) |-> resp_r[frc_pkg::IDX_VIN_LOW] == 8'hB8;
   endproperty
   a_vl_reset: assert property (p_vl_reset)
      else $error("Input low reset value wrong.");

   property p_oc_shut;
      @(posedge clk) disable iff (rst)
      (fault_in[0] && resp_r[frc_pkg::IDX_OC][7:6] == 2'h3 && !gate_on_cmd)
         |=> gate_off;
   endproperty
   a_oc_shut: assert property (p_oc_shut)
      else $error("Overcurrent fault did not shut the gate.");

   property p_ot_shut;
      @(posedge clk) disable iff (rst)
      (fault_in[1] && resp_r[frc_pkg::IDX_OT][7:6] == 2'h2 && !gate_on_cmd)
         |=> gate_off;
   endproperty
   a_ot_shut: assert property (p_ot_shut)
      else $error("Overtemperature fault did not shut the gate.");
endmodule : frc_top

/* File: tb/frc_host.sv */
// Command port host model for the fault response bench.
`timescale 1ns/1ps
module frc_host (
   // Clock.
   input wire logic clk,
   // Requests.
   output frc_pkg::frc_req_s req
);
   initial begin
      req = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // One strobe cycle, then the byte lines show the inverse of the last.
   task automatic xfer(input logic w, input logic [7:0] c,
                       input logic [7:0] d);
      @(posedge clk);
      #1;
      req = '{wr: w, rd: !w, cmd: c, data: d};
      @(posedge clk);
      #1;
      req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: ~d};
   endtask : xfer
endmodule : frc_host

/* File: tb/frc_top_tb.sv */
// Self-checking bench for the fault response configuration block.
`timescale 1ns/1ps
module frc_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] fault_in = 4'h0;
   logic gate_on_cmd = 1'b0;
   frc_pkg::frc_req_s req;
   logic [7:0] rd_data;
   logic rd_valid;
   logic wr_refused;
   logic gate_off;
   logic write_lock_full;
   logic [3:0] latched_off;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h00C9DEE8;
   int n_errors = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   frc_host host_u (.clk(clk), .req(req));
   frc_top dut_u (.clk(clk), .rst(rst), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .wr_refused(wr_refused), .fault_in(fault_in),
      .gate_on_cmd(gate_on_cmd), .gate_off(gate_off),
      .latched_off(latched_off), .write_lock_full(write_lock_full));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] c, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.xfer(1'b0, c, 8'h00);
   endtask : rd
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      host_u.xfer(1'b1, c, d);
   endtask : wr
   task automatic pulse(input logic [3:0] f);
      @(posedge clk);
      #1;
      fault_in = f;
      @(posedge clk);
      #1;
      fault_in = 4'h0;
   endtask : pulse
   task automatic clr;
      @(posedge clk);
      #1;
      gate_on_cmd = 1'b1;
      @(posedge clk);
      #1;
      gate_on_cmd = 1'b0;
   endtask : clr
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   // The read monitor takes the oldest expected byte on each valid pulse.
   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("[ERR] %0t read without request", $time);
         end else begin
            chk(rd_data, exp_q.pop_front());
         end
      end
   end
   initial begin
      #20000;
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report;
   end
   initial begin
      logic [7:0] d;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      rd(frc_pkg::CMD_OC, 8'hC0);
      rd(frc_pkg::CMD_OT, 8'h80);
      rd(frc_pkg::CMD_VIN_HIGH, 8'hB8);
      rd(frc_pkg::CMD_VIN_LOW, 8'hB8);
      rd(frc_pkg::CMD_WRITE_PROTECT, 8'h00);
      rd(8'h33, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         wr(frc_pkg::CMD_VIN_LOW, d);
         rd(frc_pkg::CMD_VIN_LOW, d & 8'hF8);
      end
      $display("random writes done");
      wr(frc_pkg::CMD_WRITE_PROTECT, 8'h80);
      chk({7'h0, write_lock_full}, 8'h01);
      wr(frc_pkg::CMD_OC, 8'h00);
      chk({7'h0, wr_refused}, 8'h01);
      rd(frc_pkg::CMD_OC, 8'hC0);
      wr(frc_pkg::CMD_OT, 8'h00);
      chk({7'h0, wr_refused}, 8'h01);
      rd(frc_pkg::CMD_OT, 8'h80);
      wr(frc_pkg::CMD_WRITE_PROTECT, 8'h00);
      chk({7'h0, write_lock_full}, 8'h00);
      $display("write lock done");
      wr(frc_pkg::CMD_OC, 8'h00);
      chk({7'h0, wr_refused}, 8'h00);
      pulse(4'h1);
      chk({7'h0, gate_off}, 8'h00);
      wr(frc_pkg::CMD_OC, 8'hC0);
      pulse(4'h1);
      chk({7'h0, gate_off}, 8'h01);
      @(posedge clk);
      #1;
      chk({4'h0, latched_off}, 8'h01);
      clr;
      chk({3'h0, latched_off, gate_off}, 8'h00);
      wr(frc_pkg::CMD_OC, 8'h80);
      pulse(4'h1);
      chk({3'h0, latched_off, gate_off}, 8'h00);
      wr(frc_pkg::CMD_OT, 8'hC0);
      pulse(4'h2);
      chk({3'h0, latched_off, gate_off}, 8'h00);
      wr(frc_pkg::CMD_OT, 8'h90);
      repeat (2) pulse(4'h2);
      @(posedge clk);
      #1;
      chk({4'h0, latched_off}, 8'h00);
      pulse(4'h2);
      @(posedge clk);
      #1;
      chk({4'h0, latched_off}, 8'h02);
      clr;
      repeat (8) pulse(4'h4);
      chk({3'h0, latched_off, gate_off}, 8'h01);
      clr;
      wr(frc_pkg::CMD_VIN_LOW, 8'hB8);
      pulse(4'h8);
      chk({3'h0, latched_off, gate_off}, 8'h01);
      $display("fault actions done");
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({3'h0, latched_off, gate_off}, 8'h00);
      rd(frc_pkg::CMD_OC, 8'hC0);
      rd(frc_pkg::CMD_OT, 8'h80);
      $display("second reset done");
      repeat (2) @(posedge clk);
      if (exp_q.size() != 0) begin
         n_errors++;
         $display("[ERR] %0t reads left unanswered", $time);
      end
      final_report;
   end
endmodule : frc_top_tb
